// ### sar_adc_pkg.sv
// Package: register map, field layout, mode codes and timing for the ADC sequencer
//
// Function
// - Upper result register shows result bits 9..2, resets to zero.
// - Lower register: result bits 1..0 on 7..6, done on 5, active on 4.
// - Done flag is 0 before or during conversion, 1 after; flags read-only. Code leaves it at 1 through repeat-mode restarts.
// - Reading the upper result register clears the done flag.
// - Active flag sets at start, clears at a single-shot finish and on standby entry.
// - Bits 3..0 of the lower register are undefined; reader ignores them.
// - Bits 7 and 6 of control register two read as undefined.
// - Standby resets control register two and blocks writes until run mode.
// - Mode 01 plus start bit begins converting the selected channel.
// - On completion store result, set done flag, pulse interrupt together.
// - Start bit clears itself once its conversion has begun.
// - Mode 11 restarts the same channel each time a conversion completes.
// - Writing mode 00 halts at once; partial value is not stored.
// - Result is stored after the configured conversion time elapses.
// - A new start clears done; old result stays until new one completes.
// - Standby aborts conversion, resets both control regs, loses results.
// - After standby the block stays idle until software restarts it.
// - In standby the analog reference is disconnected from the converter.
// - Each conversion gives a 10-bit unsigned code rising with input.
// - Mode field: 00 off, 01 software start, 10 reserved, 11 repeat.
// - Time codes 000,010..110 give 39..1248 clocks; 001,111 reserved.
// - Channel codes 0000..0111 pick inputs 0..7; others reserved.
// - Ladder bit 0: ladder on only while converting; 1: always on.
package sar_adc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CONTROL_ONE  = 8'h1C;
  localparam logic [7:0] ADDR_CONTROL_TWO  = 8'h1D;
  localparam logic [7:0] ADDR_LOWER_STATUS = 8'h1E;
  localparam logic [7:0] ADDR_UPPER        = 8'h1F;

  // Reset values
  localparam logic [7:0] CONTROL_ONE_INIT = 8'h10;
  localparam logic [7:0] CONTROL_TWO_INIT = 8'h10;
  localparam logic [7:0] UPPER_INIT       = 8'h00;

  // Control one fields
  localparam int START_BIT   = 7;
  localparam int MODE_HI     = 6;
  localparam int MODE_LO     = 5;
  localparam int AIN_DIS_BIT = 4;
  localparam int CHAN_HI     = 3;

  // Control two fields
  localparam int LADDER_BIT = 5;
  localparam int TIME_HI    = 3;
  localparam int TIME_LO    = 1;
  localparam logic [7:0] CONTROL_TWO_WMASK = 8'h3F;

  // Lower status fields
  localparam int DONE_BIT   = 5;
  localparam int ACTIVE_BIT = 4;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_SOFT   = 2'b01,
    MODE_RSVD   = 2'b10,
    MODE_REPEAT = 2'b11
  } op_mode_type;

  // Conversion times in system clock periods
  localparam logic [10:0] TIME_39   = 11'h027;
  localparam logic [10:0] TIME_78   = 11'h04E;
  localparam logic [10:0] TIME_156  = 11'h09C;
  localparam logic [10:0] TIME_312  = 11'h138;
  localparam logic [10:0] TIME_624  = 11'h270;
  localparam logic [10:0] TIME_1248 = 11'h4E0;

  localparam logic [3:0] CHAN_LAST = 4'h7;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

endpackage : sar_adc_pkg

// ### sar_adc_sequencer.sv
// Module: conversion sequencer, control and result registers of the ADC
`timescale 1ns/100ps
module sar_adc_sequencer #(
  parameter int RES_WIDTH = 10
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 RST,
  input  wire sar_adc_pkg::bus_req_type BUS_REQ,
  output logic [7:0]                RDATA,
  input  wire logic                 STANDBY,
  input  wire logic [RES_WIDTH-1:0] SAR_CODE,
  output logic                      SAMPLE,
  output logic [2:0]                CHANNEL,
  output logic                      CHANNEL_VALID,
  output logic                      ANALOG_INPUT_DISABLE,
  output logic                      LADDER_ON,
  output logic                      REF_CONNECT,
  output logic                      CONV_DONE_IRQ
);

  typedef enum logic [1:0] {IDLE, CONVERT} seq_type;

  logic [7:0]           conv_control_one;
  logic [7:0]           conv_control_two;
  logic [RES_WIDTH-1:0] result;
  logic                 conv_done_flag;
  logic                 conv_active_flag;
  logic [10:0]          count;
  logic [10:0]          conv_time;
  logic [3:0]           chan_latched;
  logic                 standby_meta;
  logic                 standby_sync;
  seq_type              state;
  logic                 start_conv;
  logic                 finish;
  logic                 halt;
  logic                 wr_one;
  logic                 wr_two;
  logic                 rd_upper;
  sar_adc_pkg::op_mode_type mode;

  // Conversion time decode; reserved codes fall back to the longest time
  function automatic logic [10:0] time_decode(input logic [2:0] code);
    case (code)
      3'h0:    time_decode = sar_adc_pkg::TIME_39;
      3'h2:    time_decode = sar_adc_pkg::TIME_78;
      3'h3:    time_decode = sar_adc_pkg::TIME_156;
      3'h4:    time_decode = sar_adc_pkg::TIME_312;
      3'h5:    time_decode = sar_adc_pkg::TIME_624;
      3'h6:    time_decode = sar_adc_pkg::TIME_1248;
      default: time_decode = sar_adc_pkg::TIME_1248;
    endcase
  endfunction : time_decode

  // Register strobe decode, shared by the control, flag and check logic
  function automatic logic bus_hit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] target);
    bus_hit = strobe && addr == target;
  endfunction : bus_hit

  // Standby comes from the power controller on another timing; synchronise
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      standby_meta <= 1'b0;
      standby_sync <= 1'b0;
    end else begin
      standby_meta <= STANDBY;
      standby_sync <= standby_meta;
    end
  end

  // Decoded strobes; one place to change if the map moves
  assign wr_one   = bus_hit(BUS_REQ.wr, BUS_REQ.addr,
                            sar_adc_pkg::ADDR_CONTROL_ONE);
  assign wr_two   = bus_hit(BUS_REQ.wr, BUS_REQ.addr,
                            sar_adc_pkg::ADDR_CONTROL_TWO);
  assign rd_upper = bus_hit(BUS_REQ.rd, BUS_REQ.addr,
                            sar_adc_pkg::ADDR_UPPER);

  assign mode = sar_adc_pkg::op_mode_type'(
    conv_control_one[sar_adc_pkg::MODE_HI:sar_adc_pkg::MODE_LO]);

  // Start only on a legal mode; reserved 10 never starts
  assign start_conv = (state == IDLE) && !standby_sync &&
    conv_control_one[sar_adc_pkg::START_BIT] &&
    (mode == sar_adc_pkg::MODE_SOFT ||
     mode == sar_adc_pkg::MODE_REPEAT);
  assign halt   = standby_sync || mode == sar_adc_pkg::MODE_OFF;
  assign finish = (state == CONVERT) && !halt && count == 11'h001;

  // Control register one; standby holds it at reset value
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      conv_control_one <= sar_adc_pkg::CONTROL_ONE_INIT;
    end else if (standby_sync) begin
      conv_control_one <= sar_adc_pkg::CONTROL_ONE_INIT;
    end else if (wr_one) begin
      conv_control_one <= BUS_REQ.wdata;
    end else if (start_conv) begin
      conv_control_one[sar_adc_pkg::START_BIT] <= 1'b0;
    end
  end

  // Control register two; writes blocked in standby
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      conv_control_two <= sar_adc_pkg::CONTROL_TWO_INIT;
    end else if (standby_sync) begin
      conv_control_two <= sar_adc_pkg::CONTROL_TWO_INIT;
    end else if (wr_two) begin
      conv_control_two <= BUS_REQ.wdata & sar_adc_pkg::CONTROL_TWO_WMASK;
    end
  end

  // Sequencer: counts the conversion time with settings caught at start
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state        <= IDLE;
      count        <= 11'h000;
      conv_time    <= sar_adc_pkg::TIME_39;
      chan_latched <= 4'h0;
    end else begin
      case (state)
        IDLE: begin
          if (start_conv) begin
            state        <= CONVERT;
            conv_time    <= time_decode(conv_control_two[
              sar_adc_pkg::TIME_HI:sar_adc_pkg::TIME_LO]);
            count        <= time_decode(conv_control_two[
              sar_adc_pkg::TIME_HI:sar_adc_pkg::TIME_LO]);
            chan_latched <= conv_control_one[sar_adc_pkg::CHAN_HI:0];
          end
        end
        CONVERT: begin
          if (halt) begin
            state <= IDLE;
          end else if (finish) begin
            // Repeat mode restarts at once on the same channel
            if (mode == sar_adc_pkg::MODE_REPEAT) begin
              count <= conv_time;
            end else begin
              state <= IDLE;
            end
          end else begin
            count <= count - 11'h001;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Active flag follows the sequencer, so it stays high across repeats
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      conv_active_flag <= 1'b0;
    end else if (halt) begin
      conv_active_flag <= 1'b0;
    end else if (start_conv) begin
      conv_active_flag <= 1'b1;
    end else if (finish && mode != sar_adc_pkg::MODE_REPEAT) begin
      conv_active_flag <= 1'b0;
    end
  end

  // Result: only a full conversion stores; standby loses it
  always_ff @(posedge REF_CLK) begin
    if (RST || standby_sync) begin
      result <= '0;
    end else if (finish) begin
      result <= SAR_CODE;
    end
  end

  // Done flag: completion wins over a clearing read in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RST || standby_sync) begin
      conv_done_flag <= 1'b0;
    end else if (finish) begin
      conv_done_flag <= 1'b1;
    end else if (start_conv) begin
      conv_done_flag <= 1'b0;
    end else if (rd_upper) begin
      conv_done_flag <= 1'b0;
    end
  end

  // Interrupt pulse on completion
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      CONV_DONE_IRQ <= 1'b0;
    end else begin
      CONV_DONE_IRQ <= finish;
    end
  end

  // Read data one cycle after the strobe; undefined bits read as zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        sar_adc_pkg::ADDR_CONTROL_ONE:  RDATA <= conv_control_one;
        sar_adc_pkg::ADDR_CONTROL_TWO:
          RDATA <= conv_control_two & sar_adc_pkg::CONTROL_TWO_WMASK;
        sar_adc_pkg::ADDR_LOWER_STATUS:
          RDATA <= {result[1:0], conv_done_flag, conv_active_flag,
                    4'h0};
        sar_adc_pkg::ADDR_UPPER:        RDATA <= result[RES_WIDTH-1:2];
        default:                        RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // Analog side controls
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SAMPLE               <= 1'b0;
      CHANNEL              <= 3'h0;
      CHANNEL_VALID        <= 1'b0;
      ANALOG_INPUT_DISABLE <= 1'b1;
      LADDER_ON            <= 1'b0;
      REF_CONNECT          <= 1'b0;
    end else begin
      // Repeat restarts sample too, so the hold stage sees every run
      SAMPLE        <= start_conv ||
                       (finish && mode == sar_adc_pkg::MODE_REPEAT);
      CHANNEL       <= chan_latched[2:0];
      CHANNEL_VALID <= chan_latched <= sar_adc_pkg::CHAN_LAST;
      ANALOG_INPUT_DISABLE <= conv_control_one[sar_adc_pkg::AIN_DIS_BIT];
      LADDER_ON     <= !standby_sync && (state == CONVERT ||
                       conv_control_two[sar_adc_pkg::LADDER_BIT]);
      REF_CONNECT   <= !standby_sync;
    end
  end

  // Assertions share one clock and sleep while reset is high
  default clocking cb_assert @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // A conversion that ran its full time
  sequence s_finish;
    finish;
  endsequence

  // What software sees one edge after a completion
  sequence s_completed;
    conv_done_flag && CONV_DONE_IRQ && result == $past(SAR_CODE);
  endsequence

  // Software stop; standby is left out as it also wipes the result
  sequence s_soft_halt;
    state == CONVERT && mode == sar_adc_pkg::MODE_OFF && !standby_sync;
  endsequence

  // Upper read that does not collide with a completion
  sequence s_upper_read;
    rd_upper && !finish;
  endsequence

  // A conversion launch from idle
  sequence s_start;
    start_conv;
  endsequence

  // Result, done flag and interrupt appear together
  a_done_on_finish: assert property (
    s_finish |=> s_completed)
    else $error("done, irq or result missing after finish");

  // Start bit drops unless software rewrites it in the same cycle
  a_start_self_clear: assert property (
    s_start and !wr_one |=> !conv_control_one[sar_adc_pkg::START_BIT])
    else $error("start bit did not clear");

  // Active flag rises with the launch
  a_active_at_start: assert property (
    s_start |=> conv_active_flag)
    else $error("active flag not set at start");

  // Mode 00 stops at once and leaves the old result
  a_halt_no_store: assert property (
    s_soft_halt |=> state == IDLE && $stable(result))
    else $error("halt stored a value");

  // Standby puts both control registers back to their reset values
  a_standby_clears: assert property (
    standby_sync |=> conv_control_one == sar_adc_pkg::CONTROL_ONE_INIT &&
      conv_control_two == sar_adc_pkg::CONTROL_TWO_INIT && !conv_active_flag)
    else $error("standby did not reset control");

  // No reference current while the core sleeps
  a_ref_cut: assert property (
    standby_sync |=> !REF_CONNECT && !LADDER_ON)
    else $error("reference connected in standby");

  // Reading the upper byte consumes the done flag
  a_upper_read_clr: assert property (
    s_upper_read |=> !conv_done_flag)
    else $error("upper read did not clear done");

  // Repeat mode keeps the active flag through each restart
  a_repeat_active: assert property (
    s_finish and mode == sar_adc_pkg::MODE_REPEAT |=> conv_active_flag)
    else $error("active dropped in repeat");

  // A fresh start clears done but keeps the last result
  a_keep_old_result: assert property (
    s_start |=> !conv_done_flag && $stable(result))
    else $error("new start changed old result");

  // The completion interrupt is a single-cycle pulse
  a_irq_one_pulse: assert property (
    CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
    else $error("interrupt held longer than one cycle");

  // The hold stage is told about every launch
  a_sample_start: assert property (
    s_start |=> SAMPLE)
    else $error("no sample pulse at start");

  // Standby throws away the last result and its flag
  a_standby_lost: assert property (
    standby_sync |=> result == '0 && !conv_done_flag)
    else $error("result survived standby");

  // Done only ever rises out of a completion
  a_done_source: assert property (
    $rose(conv_done_flag) |-> $past(finish))
    else $error("done set without completion");

  // Active only drops on a stop or a single-shot completion
  a_active_drop: assert property (
    $fell(conv_active_flag) |-> $past(halt) || $past(finish))
    else $error("active dropped without cause");

  // The timer stays inside the latched conversion time
  a_count_range: assert property (
    state == CONVERT |-> count != 11'h000 && count <= conv_time)
    else $error("conversion counter out of range");

  // Each running cycle takes one step off the timer
  a_count_step: assert property (
    state == CONVERT && !halt && !finish |=> count == $past(count) - 11'h001)
    else $error("conversion counter skipped");

  // The ladder is connected while converting
  a_ladder_run: assert property (
    state == CONVERT && !standby_sync |=> LADDER_ON)
    else $error("ladder off during conversion");

  // The reserved mode code never launches
  a_rsvd_idle: assert property (
    state == IDLE && mode == sar_adc_pkg::MODE_RSVD |=> state == IDLE)
    else $error("reserved mode started a conversion");

  // The reference comes back once the core runs again
  a_ref_on_run: assert property (
    !standby_sync |=> REF_CONNECT)
    else $error("reference not connected in run mode");

  // No completion interrupt out of the idle state
  a_idle_no_irq: assert property (
    state == IDLE |=> !CONV_DONE_IRQ)
    else $error("interrupt raised while idle");

endmodule : sar_adc_sequencer

// ### sar_adc_sequencer_tb.sv
// Self-checking testbench for the ADC conversion sequencer
`timescale 1ns/100ps
module sar_adc_sequencer_tb;
  logic                     REF_CLK;
  logic                     RST;
  sar_adc_pkg::bus_req_type BUS_REQ;
  logic [7:0]               RDATA;
  logic                     STANDBY;
  logic [9:0]               SAR_CODE;
  logic                     SAMPLE;
  logic [2:0]               CHANNEL;
  logic                     CHANNEL_VALID;
  logic                     ANALOG_INPUT_DISABLE;
  logic                     LADDER_ON;
  logic                     REF_CONNECT;
  logic                     CONV_DONE_IRQ;
  int                       failures;
  int                       n_tests;
  int                       n_samples;
  int                       cycles;
  int                       seed;
  int                       n;
  int                       t0;
  int                       t_tab[8];
  logic [9:0]               res_q[$];
  logic [9:0]               m_res;
  logic [9:0]               m_old;
  logic [7:0]               rd_val;

  sar_adc_sequencer i_dut (
    .REF_CLK              (REF_CLK),
    .RST                  (RST),
    .BUS_REQ              (BUS_REQ),
    .RDATA                (RDATA),
    .STANDBY              (STANDBY),
    .SAR_CODE             (SAR_CODE),
    .SAMPLE               (SAMPLE),
    .CHANNEL              (CHANNEL),
    .CHANNEL_VALID        (CHANNEL_VALID),
    .ANALOG_INPUT_DISABLE (ANALOG_INPUT_DISABLE),
    .LADDER_ON            (LADDER_ON),
    .REF_CONNECT          (REF_CONNECT),
    .CONV_DONE_IRQ        (CONV_DONE_IRQ)
  );

  // 25 MHz system clock
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  // Cycle count; the ceiling covers the longest conversion times with margin
  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    // Launches seen by the hold stage, counted for the closing check
    if (SAMPLE === 1'b1) n_samples <= n_samples + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bus write: one strobe cycle, released at the edge that takes it
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge REF_CLK);
    BUS_REQ <= '0;
  endtask : wr

  // Bus read: data stand only in the cycle after the strobe
  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge REF_CLK);
    BUS_REQ <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge REF_CLK);
    BUS_REQ <= '0;
    #1 rd_val = RDATA;
    chk(16'(rd_val), 16'(e));
  endtask : rchk

  // Count cycles until the completion pulse, bounded
  task wait_irq;
    n = 0;
    do begin
      @(posedge REF_CLK);
      #1 n++;
    end while (CONV_DONE_IRQ !== 1'b1 && n < 2000);
  endtask : wait_irq

  // Count completion pulses over a fixed quiet window
  task quiet(input int k);
    n = 0;
    repeat (k) begin
      @(posedge REF_CLK);
      #1 if (CONV_DONE_IRQ === 1'b1) n++;
    end
  endtask : quiet

  initial begin
    seed = 52;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    n_samples = 0;
    t_tab = '{39, 1248, 78, 156, 312, 624, 1248, 1248};
    m_old = 10'h000;
    RST = 1'b1;
    BUS_REQ = '0;
    STANDBY = 1'b0;
    SAR_CODE = 10'h000;
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    // Reset values and an unmapped address
    rchk(sar_adc_pkg::ADDR_UPPER, 8'h00);
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, 8'h00);
    rchk(sar_adc_pkg::ADDR_CONTROL_ONE, 8'h10);
    rchk(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h10);
    rchk(8'h20, 8'h00);
    chk(16'(LADDER_ON), 16'h0000);
    // Software start at every time code; odd passes leave done set
    for (int c = 0; c < 8; c++) begin
      m_res = 10'($random(seed));
      SAR_CODE <= m_res;
      wr(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h10 | 8'(c << 1));
      rchk(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h10 | 8'(c << 1));
      wr(sar_adc_pkg::ADDR_CONTROL_ONE, 8'hA3);
      #1 t0 = cycles;
      rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {m_old[1:0], 6'h10});
      rchk(sar_adc_pkg::ADDR_UPPER, m_old[9:2]);
      rchk(sar_adc_pkg::ADDR_CONTROL_ONE, 8'h23);
      chk(16'({CHANNEL_VALID, CHANNEL}), 16'h000B);
      chk(16'({LADDER_ON, ANALOG_INPUT_DISABLE}), 16'h0002);
      wait_irq();
      n = cycles - t0;
      chk(16'(n >= t_tab[c] + 1 && n <= t_tab[c] + 3), 16'h0001);
      rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {m_res[1:0], 6'h20});
      if (c % 2 == 0) begin
        rchk(sar_adc_pkg::ADDR_UPPER, m_res[9:2]);
        rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {m_res[1:0], 6'h00});
      end
      m_old = m_res;
    end
    // Repeat mode: back-to-back results with the active flag held
    wr(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h10);
    repeat (2) res_q.push_back(10'($random(seed)));
    SAR_CODE <= res_q[0];
    wr(sar_adc_pkg::ADDR_CONTROL_ONE, 8'hE3);
    wait_irq();
    SAR_CODE <= res_q[1];
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {res_q[0][1:0], 6'h30});
    wait_irq();
    chk(16'(n <= 42), 16'h0001);
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {res_q[1][1:0], 6'h30});
    rchk(sar_adc_pkg::ADDR_UPPER, res_q[1][9:2]);
    // Mode 00 in mid-conversion: stop at once, nothing stored
    repeat (10) @(posedge REF_CLK);
    SAR_CODE <= ~res_q[1];
    wr(sar_adc_pkg::ADDR_CONTROL_ONE, 8'h03);
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {res_q[1][1:0], 6'h00});
    quiet(60);
    chk(16'(n), 16'h0000);
    rchk(sar_adc_pkg::ADDR_UPPER, res_q[1][9:2]);
    // Reserved mode never starts; ladder bit holds the ladder on
    wr(sar_adc_pkg::ADDR_CONTROL_ONE, 8'hC3);
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, {res_q[1][1:0], 6'h00});
    wr(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h30);
    repeat (2) @(posedge REF_CLK);
    #1 chk(16'(LADDER_ON), 16'h0001);
    // Standby in mid-conversion aborts and locks the control registers
    wr(sar_adc_pkg::ADDR_CONTROL_ONE, 8'hA3);
    repeat (5) @(posedge REF_CLK);
    STANDBY <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    #1 chk(16'({REF_CONNECT, LADDER_ON}), 16'h0000);
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, 8'h00);
    rchk(sar_adc_pkg::ADDR_UPPER, 8'h00);
    wr(sar_adc_pkg::ADDR_CONTROL_ONE, 8'hA3);
    wr(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h3E);
    rchk(sar_adc_pkg::ADDR_CONTROL_ONE, 8'h10);
    rchk(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h10);
    STANDBY <= 1'b0;
    quiet(60);
    chk(16'({REF_CONNECT, 8'(n)}), 16'h0100);
    rchk(sar_adc_pkg::ADDR_LOWER_STATUS, 8'h00);
    wr(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h14);
    rchk(sar_adc_pkg::ADDR_CONTROL_TWO, 8'h14);
    // Eight single starts, one repeat start with two restarts, one aborted
    chk(16'(n_samples), 16'h000C);
    report_and_stop();
  end
endmodule : sar_adc_sequencer_tb
